// ### include/tsr_defines.vh
// constants for the thermal sensor register file: pointer values,
// reset values and field positions.
// assumes inclusion by bare name from design files.
`ifndef TSR_DEFINES_VH
`define TSR_DEFINES_VH

// ===========================================================
// pointer values
`define TSR_P_LOC_HI 8'h00
`define TSR_P_REM_S_HI 8'h01
`define TSR_P_STAT1 8'h02
`define TSR_P_GCFG_A 8'h03
`define TSR_P_RATE_A 8'h04
`define TSR_P_ROS_A 8'h07
`define TSR_P_GCFG_B 8'h09
`define TSR_P_RATE_B 8'h0A
`define TSR_P_ROS_B 8'h0D
`define TSR_P_ONESHOT 8'h0F
`define TSR_P_REM_S_LO 8'h10
`define TSR_P_OFS_HI 8'h11
`define TSR_P_OFS_LO 8'h12
`define TSR_P_RCRIT 8'h19
`define TSR_P_LLIM 8'h20
`define TSR_P_HYST 8'h21
`define TSR_P_LOC_LO 8'h30
`define TSR_P_REM_U_HI 8'h31
`define TSR_P_REM_U_LO 8'h32
`define TSR_P_STAT2 8'h33
`define TSR_P_DCFG 8'hBF
`define TSR_P_MAKER 8'hFE
`define TSR_P_REV 8'hFF

// ===========================================================
// reset values
`define TSR_RST_PTR 8'h00
`define TSR_RST_GCFG 8'h00
`define TSR_RST_RATE 2'h2
`define TSR_RST_ROS 8'h55
`define TSR_RST_RCRIT 8'h6E
`define TSR_RST_LLIM 7'h55
`define TSR_RST_HYST 5'h0A
`define TSR_RST_DCFG 8'h1F
`define TSR_RST_OFS 8'h00

// ===========================================================
// writable masks and fixed bits
`define TSR_GCFG_WMASK 8'h5E
`define TSR_DCFG_WMASK 8'h7E
`define TSR_DCFG_ONES 8'h01

// ===========================================================
// field positions
`define TSR_GCFG_STANDBY 6
`define TSR_GCFG_RCRIT_MASK 4
`define TSR_GCFG_ROS_MASK 3
`define TSR_GCFG_LCRIT_MASK 2
`define TSR_GCFG_LOS_MASK 1
`define TSR_DCFG_PINSEL 6
`define TSR_DCFG_FOS_MASK 5
`define TSR_DCFG_FCRIT_MASK 4
`define TSR_DCFG_MODEL 3
`define TSR_ST1_BUSY 7
`define TSR_ST1_RCRIT 4
`define TSR_ST1_ROS 3
`define TSR_ST1_FAULT 2
`define TSR_ST1_LOC 0
`define TSR_ST2_NRDY 7

// ===========================================================
// diode fault readings
`define TSR_FAULT_SIGNED 13'h1000
`define TSR_FAULT_UNSIGNED 13'h1FFF

`endif

// ### hw/tsr_alarm.v
// limit comparators with shared hysteresis for the alarm outputs.
// assumes temperatures are updated before the one-cycle update pulse.
`include "tsr_defines.vh"
`default_nettype none

module tsr_alarm (
  input wire core_clk,
  input wire sys_rst,
  input wire update,
  input wire [7:0] local_int,
  input wire [7:0] remote_uint,
  input wire diode_fault,
  input wire [7:0] ros_limit,
  input wire [7:0] rcrit_limit,
  input wire [6:0] local_limit,
  input wire [4:0] hyst,
  input wire [7:0] gcfg,
  input wire [7:0] dcfg,
  output reg loc_over_r,
  output reg ros_over_r,
  output reg rcrit_over_r,
  output reg os_act_r,
  output reg crit_act_r
);

  // ===========================================================
  // comparisons
  wire loc_pos = ~local_int[7];
  wire loc_over = loc_pos & (local_int[6:0] > local_limit);
  wire ros_over = remote_uint > ros_limit;
  wire rcrit_over = remote_uint > rcrit_limit;
  // nine bits keep limit minus hysteresis from wrapping below zero
  wire [8:0] loc_thr = {2'b00, local_limit} - {4'h0, hyst};
  wire [8:0] ros_thr = {1'b0, ros_limit} - {4'h0, hyst};
  wire [8:0] rcr_thr = {1'b0, rcrit_limit} - {4'h0, hyst};
  // a limit below the hysteresis leaves no clear band for positive values
  wire loc_clr = ~loc_pos |
    (~loc_thr[8] & ({2'b00, local_int[6:0]} < loc_thr));
  wire ros_clr = ~ros_thr[8] & ({1'b0, remote_uint} < ros_thr);
  wire rcr_clr = ~rcr_thr[8] & ({1'b0, remote_uint} < rcr_thr);

  wire os_set = (loc_over & ~gcfg[`TSR_GCFG_LOS_MASK]) |
    (ros_over & ~gcfg[`TSR_GCFG_ROS_MASK]) |
    (diode_fault & ~dcfg[`TSR_DCFG_FOS_MASK]);
  wire crit_set = (loc_over & ~gcfg[`TSR_GCFG_LCRIT_MASK]) |
    (rcrit_over & ~gcfg[`TSR_GCFG_RCRIT_MASK]) |
    (diode_fault & ~dcfg[`TSR_DCFG_FCRIT_MASK]);
  wire os_clr = loc_clr & ros_clr & ~diode_fault;
  wire crit_clr = loc_clr & rcr_clr & ~diode_fault;

  // ===========================================================
  // status flags follow each update; alarm state held between the two thresholds
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loc_over_r <= 1'b0;
      ros_over_r <= 1'b0;
      rcrit_over_r <= 1'b0;
      os_act_r <= 1'b0;
      crit_act_r <= 1'b0;
    end
    else if (update)
    begin
      loc_over_r <= loc_over;
      ros_over_r <= ros_over;
      rcrit_over_r <= rcrit_over;
      if (os_set)
        os_act_r <= 1'b1;
      else if (os_clr)
        os_act_r <= 1'b0;
      if (crit_set)
        crit_act_r <= 1'b1;
      else if (crit_clr)
        crit_act_r <= 1'b0;
    end
  end

endmodule // tsr_alarm

`default_nettype wire

// ### hw/tsr_regs.v
// register file of a two-channel temperature sensor, reached through
// a latched command pointer by the bus protocol engine.
// assumes the protocol engine and conversion engine run on core_clk
// and give single-cycle strobes.
`include "tsr_defines.vh"
`default_nettype none

// How it works
// - pointers 03h and 09h reach general config
// - two-bit rate at 04h/0Ah, resets to 02h
// - write 0Fh starts one conversion in standby
// - local low byte: three fraction bits, rest zero
// - local high byte: signed whole degrees
// - remote signed high byte, same format
// - remote low: five or three bits by filter
// - unsigned remote high 31h, low 32h
// - diode config at BFh resets to 1Fh
// - remote offset high and three-bit low
// - status at 02h busy/alarms, 33h not-ready
// - remote limits: overtemp 07h/0Dh, critical 19h
// - one seven-bit local limit at 20h
// - alarms clear below limit minus hysteresis
// - pointer resets to zero, holds last value
// - high byte read freezes low byte
module tsr_regs #(
  parameter [7:0] MAKER_CODE = 8'h5A, // arbitrary value
  parameter [7:0] REVISION_CODE = 8'hA5 // arbitrary value
) (
  input wire core_clk,
  input wire sys_rst,
  input wire ptr_load,
  input wire [7:0] ptr_byte,
  input wire wr_stb,
  input wire [7:0] wr_data,
  input wire rd_stb,
  output reg [7:0] rd_data_r,
  output reg rd_valid_r,
  input wire conv_done,
  input wire [10:0] local_result,
  input wire [12:0] remote_signed_result,
  input wire [12:0] remote_unsigned_result,
  input wire diode_fault,
  input wire conv_busy,
  input wire not_ready,
  output reg one_shot_r,
  output wire standby,
  output wire [1:0] conv_rate,
  output wire filter_en,
  output wire diode_model,
  output wire [7:0] offset_high,
  output wire [2:0] offset_low,
  output wire overtemp_alarm_n,
  output wire crit_alarm_n,
  output wire alarm_or_address_pin_oe_n
);

  // ===========================================================
  // storage
  reg [7:0] ptr_r;
  reg [7:0] gcfg_r;
  reg [1:0] rate_r;
  reg [7:0] dcfg_r;
  reg [7:0] ofs_hi_r;
  reg [2:0] ofs_lo_r;
  reg [7:0] ros_lim_r;
  reg [7:0] rcrit_lim_r;
  reg [6:0] llim_r;
  reg [4:0] hyst_r;
  reg [10:0] loc_r;
  reg [12:0] rem_s_r;
  reg [12:0] rem_u_r;
  reg fault_r;
  reg upd_r;
  reg [7:0] loc_lo_hold_r;
  reg [7:0] rem_s_lo_hold_r;
  reg [7:0] rem_u_lo_hold_r;
  reg loc_lock_r;
  reg rem_s_lock_r;
  reg rem_u_lock_r;
  reg [7:0] rd_nxt;
  wire loc_over;
  wire ros_over;
  wire rcrit_over;
  wire os_act;
  wire crit_act;

  // ===========================================================
  // helpers
  function [7:0] fmt_remote_low;
    input [4:0] frac;
    input filt;
    begin
      if (filt)
        fmt_remote_low = {frac, 3'b000};
      else
        fmt_remote_low = {frac[4:2], 5'b00000};
    end
  endfunction

  function is_gcfg;
    input [7:0] p;
    begin
      is_gcfg = (p == `TSR_P_GCFG_A) || (p == `TSR_P_GCFG_B);
    end
  endfunction

  function is_rate;
    input [7:0] p;
    begin
      is_rate = (p == `TSR_P_RATE_A) || (p == `TSR_P_RATE_B);
    end
  endfunction

  function is_ros;
    input [7:0] p;
    begin
      is_ros = (p == `TSR_P_ROS_A) || (p == `TSR_P_ROS_B);
    end
  endfunction

  // ===========================================================
  // live values of the readable fields
  assign filter_en = dcfg_r[2] & dcfg_r[1];
  assign diode_model = dcfg_r[`TSR_DCFG_MODEL];
  assign standby = gcfg_r[`TSR_GCFG_STANDBY];
  assign conv_rate = rate_r;
  assign offset_high = ofs_hi_r;
  assign offset_low = ofs_lo_r;

  wire [7:0] loc_lo_live = {loc_r[2:0], 5'b00000};
  wire [7:0] rem_s_lo_live = fmt_remote_low(rem_s_r[4:0], filter_en);
  wire [7:0] rem_u_lo_live = fmt_remote_low(rem_u_r[4:0], filter_en);
  wire [7:0] stat1 = {conv_busy, 2'b00, rcrit_over, ros_over,
    fault_r, 1'b0, loc_over};
  wire [7:0] stat2 = {not_ready, 7'h00};

  // ===========================================================
  // read multiplexer; unmapped and write-only locations read zero
  always @*
  begin
    rd_nxt = 8'h00;
    case (ptr_r)
      `TSR_P_LOC_HI: rd_nxt = loc_r[10:3];
      `TSR_P_REM_S_HI: rd_nxt = rem_s_r[12:5];
      `TSR_P_REM_U_HI: rd_nxt = rem_u_r[12:5];
      `TSR_P_LOC_LO:
        rd_nxt = loc_lock_r ? loc_lo_hold_r : loc_lo_live;
      `TSR_P_REM_S_LO:
        rd_nxt = rem_s_lock_r ? rem_s_lo_hold_r : rem_s_lo_live;
      `TSR_P_REM_U_LO:
        rd_nxt = rem_u_lock_r ? rem_u_lo_hold_r : rem_u_lo_live;
      `TSR_P_STAT1: rd_nxt = stat1;
      `TSR_P_STAT2: rd_nxt = stat2;
      `TSR_P_GCFG_A, `TSR_P_GCFG_B: rd_nxt = gcfg_r;
      `TSR_P_RATE_A, `TSR_P_RATE_B:
        rd_nxt = {6'h00, rate_r};
      `TSR_P_ROS_A, `TSR_P_ROS_B: rd_nxt = ros_lim_r;
      `TSR_P_RCRIT: rd_nxt = rcrit_lim_r;
      `TSR_P_LLIM: rd_nxt = {1'b0, llim_r};
      `TSR_P_HYST: rd_nxt = {3'b000, hyst_r};
      `TSR_P_OFS_HI: rd_nxt = ofs_hi_r;
      `TSR_P_OFS_LO: rd_nxt = {ofs_lo_r, 5'b00000};
      `TSR_P_DCFG: rd_nxt = dcfg_r;
      `TSR_P_MAKER: rd_nxt = MAKER_CODE;
      `TSR_P_REV: rd_nxt = REVISION_CODE;
      default: rd_nxt = 8'h00;
    endcase
  end

  // ===========================================================
  // pointer, read data and low-byte locks
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ptr_r <= `TSR_RST_PTR;
      rd_data_r <= 8'h00;
      rd_valid_r <= 1'b0;
      loc_lock_r <= 1'b0;
      rem_s_lock_r <= 1'b0;
      rem_u_lock_r <= 1'b0;
      loc_lo_hold_r <= 8'h00;
      rem_s_lo_hold_r <= 8'h00;
      rem_u_lo_hold_r <= 8'h00;
    end
    else
    begin
      rd_valid_r <= rd_stb;
      if (ptr_load)
        ptr_r <= ptr_byte;
      if (rd_stb)
      begin
        rd_data_r <= rd_nxt;
        // each high-byte read relocks, replacing an older snapshot
        case (ptr_r)
          `TSR_P_LOC_HI:
          begin
            loc_lock_r <= 1'b1;
            loc_lo_hold_r <= loc_lo_live;
          end
          `TSR_P_REM_S_HI:
          begin
            rem_s_lock_r <= 1'b1;
            rem_s_lo_hold_r <= rem_s_lo_live;
          end
          `TSR_P_REM_U_HI:
          begin
            rem_u_lock_r <= 1'b1;
            rem_u_lo_hold_r <= rem_u_lo_live;
          end
          `TSR_P_LOC_LO: loc_lock_r <= 1'b0;
          `TSR_P_REM_S_LO: rem_s_lock_r <= 1'b0;
          `TSR_P_REM_U_LO: rem_u_lock_r <= 1'b0;
          default: rd_data_r <= rd_nxt;
        endcase
      end
    end
  end

  // ===========================================================
  // writable registers; read-only pointers fall to default
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gcfg_r <= `TSR_RST_GCFG;
      rate_r <= `TSR_RST_RATE;
      dcfg_r <= `TSR_RST_DCFG;
      ofs_hi_r <= `TSR_RST_OFS;
      ofs_lo_r <= 3'b000;
      ros_lim_r <= `TSR_RST_ROS;
      rcrit_lim_r <= `TSR_RST_RCRIT;
      llim_r <= `TSR_RST_LLIM;
      hyst_r <= `TSR_RST_HYST;
      one_shot_r <= 1'b0;
    end
    else
    begin
      one_shot_r <= 1'b0;
      if (wr_stb)
      begin
        if (is_gcfg(ptr_r))
          gcfg_r <= wr_data & `TSR_GCFG_WMASK;
        if (is_rate(ptr_r))
          rate_r <= wr_data[1:0];
        if (is_ros(ptr_r))
          ros_lim_r <= wr_data;
        case (ptr_r)
          // the data byte is irrelevant and not stored
          `TSR_P_ONESHOT: one_shot_r <= standby;
          `TSR_P_DCFG:
            dcfg_r <= (wr_data & `TSR_DCFG_WMASK) | `TSR_DCFG_ONES;
          `TSR_P_OFS_HI: ofs_hi_r <= wr_data;
          `TSR_P_OFS_LO: ofs_lo_r <= wr_data[7:5];
          `TSR_P_RCRIT: rcrit_lim_r <= wr_data;
          `TSR_P_LLIM: llim_r <= wr_data[6:0];
          `TSR_P_HYST: hyst_r <= wr_data[4:0];
          default: one_shot_r <= 1'b0;
        endcase
      end
    end
  end

  // ===========================================================
  // conversion results; a faulty diode forces the extreme remote readings
  always @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      loc_r <= 11'h000;
      rem_s_r <= 13'h0000;
      rem_u_r <= 13'h0000;
      fault_r <= 1'b0;
      upd_r <= 1'b0;
    end
    else
    begin
      upd_r <= conv_done;
      if (conv_done)
      begin
        loc_r <= local_result;
        fault_r <= diode_fault;
        rem_s_r <= diode_fault ? `TSR_FAULT_SIGNED : remote_signed_result;
        rem_u_r <= diode_fault ? `TSR_FAULT_UNSIGNED :
          remote_unsigned_result;
      end
    end
  end

  // ===========================================================
  // alarm comparators, updated once per finished conversion
  tsr_alarm u_alarm (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .update(upd_r),
    .local_int(loc_r[10:3]),
    .remote_uint(rem_u_r[12:5]),
    .diode_fault(fault_r),
    .ros_limit(ros_lim_r),
    .rcrit_limit(rcrit_lim_r),
    .local_limit(llim_r),
    .hyst(hyst_r),
    .gcfg(gcfg_r),
    .dcfg(dcfg_r),
    .loc_over_r(loc_over),
    .ros_over_r(ros_over),
    .rcrit_over_r(rcrit_over),
    .os_act_r(os_act),
    .crit_act_r(crit_act)
  );

  // open-drain outputs: low level means the pin is pulled down
  assign crit_alarm_n = ~crit_act;
  assign overtemp_alarm_n = ~(os_act & dcfg_r[`TSR_DCFG_PINSEL]);
  // in address mode the shared pin is left to the strap
  assign alarm_or_address_pin_oe_n = ~(os_act &
    dcfg_r[`TSR_DCFG_PINSEL]);

endmodule // tsr_regs

`default_nettype wire

// ### testbench/tsr_regs_asserts.sv
// checker on the register file ports, bound into tsr_regs.
// assumes one clock domain and an async active-high reset.
`default_nettype none

module tsr_regs_chk (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic ptr_load,
  input wire logic [7:0] ptr_byte,
  input wire logic wr_stb,
  input wire logic [7:0] wr_data,
  input wire logic one_shot_r,
  input wire logic standby,
  input wire logic [1:0] conv_rate,
  input wire logic filter_en,
  input wire logic diode_model,
  input wire logic [7:0] offset_high,
  input wire logic [2:0] offset_low
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ptr_q;

  // ==========================================
  // shadow pointer: an access in a load cycle uses the old value
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      ptr_q <= 8'h00;
    else if (ptr_load)
      ptr_q <= ptr_byte;
  end

  default clocking @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  // ==========================================
  // properties
  sequence s_wr(logic [7:0] a);
    wr_stb && ptr_q == a;
  endsequence
  sequence s_shot;
    s_wr(8'h0F) ##0 standby;
  endsequence
  property p_shot;
    s_shot |=> one_shot_r;
  endproperty
  property p_noshot;
    one_shot_r |-> $past(wr_stb && ptr_q == 8'h0F && standby);
  endproperty
  property p_rate_wr;
    s_wr(8'h04) or s_wr(8'h0A) |=> conv_rate == $past(wr_data[1:0]);
  endproperty
  property p_rate_hold;
    !(wr_stb && (ptr_q == 8'h04 || ptr_q == 8'h0A)) |=> $stable(conv_rate);
  endproperty
  property p_stby;
    s_wr(8'h03) or s_wr(8'h09) |=> standby == $past(wr_data[6]);
  endproperty
  property p_dcfg;
    s_wr(8'hBF) |=> diode_model == $past(wr_data[3])
      && filter_en == (&$past(wr_data[2:1]));
  endproperty
  property p_ofs_hi;
    s_wr(8'h11) |=> offset_high == $past(wr_data);
  endproperty
  property p_ofs_lo;
    s_wr(8'h12) |=> offset_low == $past(wr_data[7:5]);
  endproperty
  property p_ro;
    wr_stb && ptr_q inside {8'h00, 8'h01, 8'h02, 8'h10, 8'h30, 8'h31,
      8'h32, 8'h33, 8'hFE, 8'hFF} |=> $stable({standby, conv_rate,
      filter_en, diode_model, offset_high, offset_low});
  endproperty

  a_shot: assert property (p_shot)
    else $error("missing start pulse");
  a_noshot: assert property (p_noshot)
    else $error("stray start pulse");
  a_rate_wr: assert property (p_rate_wr)
    else $error("rate not written");
  a_rate_hold: assert property (p_rate_hold)
    else $error("rate changed unasked");
  a_stby: assert property (p_stby)
    else $error("standby not written");
  a_dcfg: assert property (p_dcfg)
    else $error("diode config not written");
  a_ofs_hi: assert property (p_ofs_hi)
    else $error("offset high not written");
  a_ofs_lo: assert property (p_ofs_lo)
    else $error("offset low not written");
  a_ro: assert property (p_ro)
    else $error("read-only write changed state");
endmodule // tsr_regs_chk

bind tsr_regs tsr_regs_chk chk_u (.core_clk, .sys_rst, .ptr_load,
  .ptr_byte, .wr_stb, .wr_data, .one_shot_r, .standby, .conv_rate,
  .filter_en, .diode_model, .offset_high, .offset_low);

`default_nettype wire

// ### testbench/tsr_host.sv
// host model issuing pointer loads, writes and reads.
// assumes requests may start on any edge after reset release.
`default_nettype none

module tsr_host (
  input wire logic core_clk,
  output logic ptr_load,
  output logic [7:0] ptr_byte,
  output logic wr_stb,
  output logic [7:0] wr_data,
  output logic rd_stb
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    ptr_load = 1'b0;
    ptr_byte = 8'h00;
    wr_stb = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
  end

  // ==========================================
  // m: 0 write, 1 read, 2 read at the latched pointer
  task xfer(input logic [7:0] p, input logic [7:0] d, input int m);
    if (m != 2)
    begin
      @(posedge core_clk);
      ptr_load <= 1'b1;
      ptr_byte <= p;
    end
    @(posedge core_clk);
    ptr_load <= 1'b0;
    ptr_byte <= ~p;
    wr_stb <= (m == 0);
    rd_stb <= (m != 0);
    wr_data <= d;
    @(posedge core_clk);
    wr_stb <= 1'b0;
    rd_stb <= 1'b0;
    // idle lines never keep the last value
    wr_data <= ~d;
  endtask
endmodule // tsr_host

`default_nettype wire

// ### testbench/thermal_sensor_register_map_test.sv
// self-checking bench for tsr_regs, bus traffic from tsr_host.
// assumes the checker is bound in by its own file.
`default_nettype none

module thermal_sensor_register_map_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, sys_rst, conv_done, diode_fault, conv_busy, not_ready;
  logic [10:0] local_result, l;
  logic [12:0] remote_signed_result, remote_unsigned_result, s, u;
  wire logic ptr_load, wr_stb, rd_stb, rd_valid_r, one_shot_r;
  wire logic [7:0] ptr_byte, wr_data, rd_data_r;
  wire logic overtemp_alarm_n, crit_alarm_n, alarm_or_address_pin_oe_n;
  wire logic [7:0] pins = {5'h00, overtemp_alarm_n, crit_alarm_n,
    alarm_or_address_pin_oe_n};
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h000107A5;
  int n_errors, n_compared, n_shot;
  logic [7:0] rp[14] = '{8'h03, 8'h09, 8'h04, 8'h0A, 8'h07, 8'h0D,
    8'h19, 8'h20, 8'h21, 8'hBF, 8'h11, 8'h12, 8'hFE, 8'hFF};
  logic [7:0] rv[14] = '{8'h00, 8'h00, 8'h02, 8'h02, 8'h55, 8'h55,
    8'h6E, 8'h55, 8'h0A, 8'h1F, 8'h00, 8'h00, 8'h5A, 8'hA5};
  logic [7:0] wp[9] = '{8'h09, 8'h03, 8'h0A, 8'h0D, 8'h19, 8'h20,
    8'h21, 8'h11, 8'h12};
  logic [7:0] mk[9] = '{8'h5E, 8'h5E, 8'h03, 8'hFF, 8'hFF, 8'h7F,
    8'h1F, 8'hFF, 8'hE0};
  logic [7:0] rq[9] = '{8'h03, 8'h09, 8'h04, 8'h07, 8'h19, 8'h20,
    8'h21, 8'h11, 8'h12};
  logic [7:0] ro[10] = '{8'h00, 8'h01, 8'h02, 8'h10, 8'h30, 8'h31,
    8'h32, 8'h33, 8'hFE, 8'hFF};

  tsr_regs dut_u (.core_clk, .sys_rst, .ptr_load, .ptr_byte, .wr_stb,
    .wr_data, .rd_stb, .rd_data_r, .rd_valid_r, .conv_done,
    .local_result, .remote_signed_result, .remote_unsigned_result,
    .diode_fault, .conv_busy, .not_ready, .one_shot_r, .standby(),
    .conv_rate(), .filter_en(), .diode_model(), .offset_high(),
    .offset_low(), .overtemp_alarm_n, .crit_alarm_n,
    .alarm_or_address_pin_oe_n);
  tsr_host host_u (.core_clk, .ptr_load, .ptr_byte, .wr_stb, .wr_data,
    .rd_stb);

  // ==========================================
  // tasks
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    repeat (8) v = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    return v;
  endfunction
  task rnd;
    seed = lfsr(seed);
  endtask
  task w(input logic [7:0] p, input logic [7:0] d);
    host_u.xfer(p, d, 0);
  endtask
  task r(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    host_u.xfer(p, 8'h00, 1);
  endtask
  task conv(input logic [10:0] a, input logic [12:0] b, input logic [12:0] c);
    @(posedge core_clk);
    conv_done <= 1'b1;
    local_result <= a;
    remote_signed_result <= b;
    remote_unsigned_result <= c;
    @(posedge core_clk);
    conv_done <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] e);
    n_compared++;
    if (got !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, e);
    end
  endtask
  task report_and_stop;
    if (n_errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================
  // clock, monitor, watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(negedge core_clk)
  begin
    if (one_shot_r === 1'b1)
      n_shot++;
    if (rd_valid_r === 1'b1)
      chk(rd_data_r, exp_q.size() > 0 ? exp_q.pop_front() : 8'hXX);
  end
  initial
  begin
    repeat (3000) @(posedge core_clk);
    n_errors++;
    report_and_stop();
  end

  // ==========================================
  // scenarios
  initial
  begin
    sys_rst = 1'b1;
    conv_done = 1'b0;
    diode_fault = 1'b0;
    conv_busy = 1'b1;
    not_ready = 1'b1;
    local_result = 11'h000;
    remote_signed_result = 13'h0000;
    remote_unsigned_result = 13'h0000;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    conv(11'h0C8, 13'h03C0, 13'h03C0);
    exp_q.push_back(8'h19);
    host_u.xfer(8'h00, 8'h00, 2);
    r(8'h02, 8'h80);
    r(8'h33, 8'h80);
    conv_busy <= 1'b0;
    not_ready <= 1'b0;
    r(8'h02, 8'h00);
    r(8'h33, 8'h00);
    for (int i = 0; i < 14; i++)
      r(rp[i], rv[i]);
    r(8'h0F, 8'h00);
    r(8'h50, 8'h00);
    w(8'h0F, 8'hFF);
    w(8'h09, 8'hFF);
    r(8'h03, 8'h5E);
    w(8'h0F, 8'h00);
    repeat (2) @(posedge core_clk);
    chk(8'(n_shot), 8'h01);
    for (int i = 0; i < 9; i++)
    begin
      rnd;
      w(wp[i], seed[7:0]);
      r(rq[i], seed[7:0] & mk[i]);
    end
    for (int i = 0; i < 10; i++)
      w(ro[i], 8'hA5);
    r(8'hFE, 8'h5A);
    r(8'hFF, 8'hA5);
    r(8'h00, 8'h19);
    r(8'h31, 8'h1E);
    repeat (4)
    begin
      rnd;
      l = seed[10:0];
      rnd;
      s = seed[12:0];
      rnd;
      u = seed[12:0];
      conv(l, s, u);
      // high bytes first so the low bytes stay from one conversion
      r(8'h00, l[10:3]);
      r(8'h01, s[12:5]);
      r(8'h31, u[12:5]);
      conv(~l, ~s, ~u);
      r(8'h30, {l[2:0], 5'h00});
      r(8'h10, {s[4:0], 3'h0});
      r(8'h32, {u[4:0], 3'h0});
      r(8'h10, {~s[4:0], 3'h0});
    end
    w(8'hBF, 8'h18);
    r(8'hBF, 8'h19);
    r(8'h10, {~s[4:2], 5'h00});
    r(8'h32, {~u[4:2], 5'h00});
    // alarms: no masks, shared pin as alarm, limits 80/100/127, hyst 5
    w(8'h09, 8'h40);
    w(8'hBF, 8'h4E);
    w(8'h0D, 8'h50);
    w(8'h19, 8'h64);
    w(8'h20, 8'h7F);
    w(8'h21, 8'h05);
    conv(11'h0C8, 13'h0B40, 13'h0B40);
    r(8'h02, 8'h08);
    @(negedge core_clk) chk(pins, 8'h02);
    // 78 degrees: below the limit but inside the hysteresis band
    conv(11'h0C8, 13'h09C0, 13'h09C0);
    r(8'h02, 8'h00);
    @(negedge core_clk) chk(pins, 8'h02);
    conv(11'h0C8, 13'h08C0, 13'h08C0);
    @(negedge core_clk) chk(pins, 8'h07);
    diode_fault <= 1'b1;
    conv(11'h0C8, 13'h08C0, 13'h08C0);
    r(8'h02, 8'h1C);
    r(8'h01, 8'h80);
    r(8'h31, 8'hFF);
    @(negedge core_clk) chk(pins, 8'h00);
    diode_fault <= 1'b0;
    repeat (3) @(posedge core_clk);
    report_and_stop();
  end
endmodule // thermal_sensor_register_map_test

`default_nettype wire
